// *** logic/aoc_pkg.sv ***
// Shared constants for the analog output channel word link
package aoc_pkg;
    // Output word layout
    localparam int          WORD_W       = 16;
    localparam int          DATA_W       = 12;
    localparam int          CH_N         = 4;
    localparam int          SEL_LO_POS   = 12;
    localparam int          SEL_HI_POS   = 13;
    localparam int          ENABLE_POS   = 14;
    localparam int          UNUSED_POS   = 15;
    localparam logic [15:0] DATA_MASK    = 16'h0fff;
    localparam logic [15:0] ENABLE_OR    = 16'h4000;
    localparam logic [4:0]  FULL_BITS    = 5'h10;
    // Current scaling in microamps
    localparam int          CUR_W        = 15;
    localparam logic [14:0] CUR_BASE_UA  = 15'h0fa0;
    localparam logic [14:0] CUR_SPAN_UA  = 15'h3e80;
    localparam logic [11:0] CODE_FULL    = 12'hfff;
    // Controller register byte offsets
    localparam logic [4:0]  OFS_CTRL     = 5'h00;
    localparam logic [4:0]  OFS_DATA0    = 5'h04;
    localparam logic [4:0]  OFS_STATUS   = 5'h14;
    // Control register fields and reset value
    localparam int          CTRL_RUN     = 0;
    localparam int          CTRL_PTR     = 1;
    localparam int          CTRL_BURST   = 2;
    localparam int          CTRL_REMOTE  = 3;
    localparam int          CTRL_ENABLE  = 4;
    localparam logic [4:0]  CTRL_RESET   = 5'h00;
    // Scan period in clock cycles
    localparam int          SCAN_CYCLES  = 16;
    typedef enum logic [1:0] {AOC_IDLE, AOC_BURST} aoc_state_e;
endpackage

// *** logic/aoc_if.sv ***
// Output word link between controller and analog output device
`timescale 1ns/100ps
interface aoc_if;
    logic [15:0] word;
    logic        word_valid;
    logic [4:0]  word_bits;
    modport dev (input word, input word_valid, input word_bits);
    modport ctl (output word, output word_valid, output word_bits);
endinterface

// *** logic/aoc_device.sv ***
// Analog output device end: word decode, channel hold, current scaling
`timescale 1ns/100ps
module aoc_device
    import aoc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    aoc_if.dev                        link,
    output logic [CH_N-1:0][CUR_W-1:0] ch_current_ua,
    output logic                      outputs_on,
    output logic                      word_taken,
    output logic                      word_dropped
);
    logic [CH_N-1:0][CUR_W-1:0] cur_r;
    logic                       on_r;
    logic                       taken_r;
    logic                       drop_r;
    logic                       full_word;
    logic [1:0]                 sel;

    // Code to current, 4 mA at zero and 20 mA at full scale
    function automatic logic [CUR_W-1:0] code_to_ua(input logic [DATA_W-1:0] d);
        logic [27:0] prod;
        prod = 28'(d) * 28'(CUR_SPAN_UA);
        return CUR_BASE_UA + CUR_W'(prod / 28'(CODE_FULL)); // R12
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Word acceptance
    assign full_word = link.word_valid && (link.word_bits == FULL_BITS); // R6
    // Select from bits 13 and 12 only, bit 15 never decoded
    assign sel       = {link.word[SEL_HI_POS], link.word[SEL_LO_POS]};  // R3 R13

    // Per-channel hold of the last accepted value
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_r <= '0;
        end else if (full_word) begin
            cur_r[sel] <= code_to_ua(link.word[DATA_W-1:0]); // R1 R14
        end
    end

    // One enable governs all channels
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            on_r <= 1'b0;
        end else if (full_word) begin
            on_r <= link.word[ENABLE_POS]; // R4
        end
    end

    // Accept and discard pulses
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            taken_r <= 1'b0;
            drop_r  <= 1'b0;
        end else begin
            taken_r <= full_word;
            drop_r  <= link.word_valid && !full_word; // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign ch_current_ua = cur_r;
    assign outputs_on    = on_r;
    assign word_taken    = taken_r;
    assign word_dropped  = drop_r;
endmodule // aoc_device

// *** logic/aoc_controller.sv ***
// Controller end: Avalon-MM registers, word building, channel sequencing
// Function
// R1 - Device takes low twelve bits as value
// R2 - Controller masks value to twelve bits first
// R3 - Select bits decode channels one to four
// R4 - Bit 14 enables all four outputs
// R5 - OR 4000 to 7000 per channel
// R6 - Whole sixteen-bit word sent; partials discarded
// R7 - One channel per scan, wrap after four
// R8 - Start at channel one if no flag
// R9 - Pointer zero to three, incremented each scan
// R10 - Optional all-four burst in one scan
// R11 - No burst in remote arrangement
// R12 - Code maps linearly onto 4 to 20 mA
// R13 - Bit 15 ignored by device
// R14 - Channel holds value until reselected
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module aoc_controller
    import aoc_pkg::*;
#(
    parameter int SCAN_LEN = SCAN_CYCLES
)(
    input  wire logic        clk,
    input  wire logic        nrst,
    aoc_if.ctl               link,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    logic [4:0]                 ctrl_r;
    logic [CH_N-1:0][DATA_W-1:0] data_r;
    logic                       wait_r;
    logic [31:0]                rdata_r;
    logic [$clog2(SCAN_LEN)-1:0] scan_cnt_r;
    logic                       scan_tick;
    logic [3:0]                 step_flags_r;
    logic                       restart_r;
    logic [1:0]                 chan_ptr_r;
    logic [1:0]                 burst_ch_r;
    aoc_state_e                 state_r;
    logic [15:0]                word_r;
    logic                       valid_r;
    logic [15:0]                sent_cnt_r;
    logic                       wr_go;
    logic                       burst_ok;
    logic [1:0]                 seq_ch;

    // Build one output word from raw data, channel and enable
    function automatic logic [15:0] make_word(input logic [DATA_W-1:0] raw,
                                              input logic [1:0] ch,
                                              input logic en);
        logic [15:0] w;
        w = 16'(raw) & DATA_MASK; // R2
        if (en) begin
            w = w | ENABLE_OR | {2'b00, ch, 12'h000}; // R5
        end else begin
            w = w | {2'b00, ch, 12'h000};
        end
        return w;
    endfunction

    // One-hot step flag to channel index
    function automatic logic [1:0] flag_to_ch(input logic [3:0] f);
        logic [1:0] c;
        c = 2'b00;
        case (f)
            4'h2:    c = 2'b01;
            4'h4:    c = 2'b10;
            4'h8:    c = 2'b11;
            default: c = 2'b00;
        endcase
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave, one wait cycle per access
    assign wr_go = avs_write && !wait_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((avs_read || avs_write) && wait_r);
        end
    end

    // Read data prepared during the wait cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && wait_r) begin
            case (avs_address)
                OFS_CTRL:   rdata_r <= {27'h0, ctrl_r};
                5'h04:      rdata_r <= {20'h0, data_r[0]};
                5'h08:      rdata_r <= {20'h0, data_r[1]};
                5'h0c:      rdata_r <= {20'h0, data_r[2]};
                5'h10:      rdata_r <= {20'h0, data_r[3]};
                OFS_STATUS: rdata_r <= {sent_cnt_r, 8'h00, state_r == AOC_BURST,
                                        chan_ptr_r, step_flags_r, restart_r};
                default:    rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Control register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_go && avs_address == OFS_CTRL) begin
            ctrl_r <= avs_writedata[4:0];
        end
    end

    // Channel data registers, low twelve bits of each write kept
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_r <= '0;
        end else if (wr_go && avs_address >= OFS_DATA0 && avs_address < OFS_STATUS
                     && avs_address[1:0] == 2'b00) begin
            data_r[2'(avs_address[4:2] - 3'h1)] <= avs_writedata[DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan timer
    assign scan_tick = (scan_cnt_r == ($clog2(SCAN_LEN))'(SCAN_LEN - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scan_cnt_r <= '0;
        end else if (scan_tick) begin
            scan_cnt_r <= '0;
        end else begin
            scan_cnt_r <= scan_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing by step flags
    assign burst_ok = ctrl_r[CTRL_BURST] && !ctrl_r[CTRL_REMOTE]; // R10 R11

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_flags_r <= 4'h0;
            restart_r    <= 1'b0;
        end else if (scan_tick && ctrl_r[CTRL_RUN] && !burst_ok
                     && !ctrl_r[CTRL_PTR]) begin
            restart_r <= step_flags_r[3]; // R7
            if (step_flags_r[3] || !(step_flags_r inside {4'h1, 4'h2, 4'h4})) begin
                step_flags_r <= 4'h1; // R8
            end else begin
                step_flags_r <= {step_flags_r[2:0], 1'b0}; // R7
            end
        end
    end

    // Sequencing by channel pointer, wraps three to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chan_ptr_r <= 2'b11;
        end else if (scan_tick && ctrl_r[CTRL_RUN] && !burst_ok
                     && ctrl_r[CTRL_PTR]) begin
            chan_ptr_r <= chan_ptr_r + 2'b01; // R9
        end
    end

    // Channel chosen for this scan
    always_comb begin
        seq_ch = 2'b00;
        if (ctrl_r[CTRL_PTR]) begin
            seq_ch = chan_ptr_r + 2'b01; // R9
        end else if (step_flags_r[3] || !(step_flags_r inside {4'h1, 4'h2, 4'h4})) begin
            seq_ch = 2'b00; // R8
        end else begin
            seq_ch = flag_to_ch({step_flags_r[2:0], 1'b0}); // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst of four words in one scan
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= AOC_IDLE;
            burst_ch_r <= 2'b00;
        end else begin
            case (state_r)
                AOC_IDLE: begin
                    if (scan_tick && ctrl_r[CTRL_RUN] && burst_ok) begin
                        state_r    <= AOC_BURST; // R10
                        burst_ch_r <= 2'b00;
                    end
                end
                AOC_BURST: begin
                    burst_ch_r <= burst_ch_r + 2'b01;
                    if (burst_ch_r == 2'b11) begin
                        state_r <= AOC_IDLE;
                    end
                end
                default: state_r <= AOC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word launch, always all sixteen bits in one strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_r  <= 16'h0000;
            valid_r <= 1'b0;
        end else if (state_r == AOC_BURST) begin
            word_r  <= make_word(data_r[burst_ch_r], burst_ch_r, ctrl_r[CTRL_ENABLE]);
            valid_r <= 1'b1; // R6
        end else if (scan_tick && ctrl_r[CTRL_RUN] && !burst_ok) begin
            word_r  <= make_word(data_r[seq_ch], seq_ch, ctrl_r[CTRL_ENABLE]); // R7
            valid_r <= 1'b1; // R6
        end else begin
            valid_r <= 1'b0;
        end
    end

    // Count of words sent
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sent_cnt_r <= 16'h0000;
        end else if (valid_r) begin
            sent_cnt_r <= sent_cnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign link.word       = word_r;
    assign link.word_valid = valid_r;
    assign link.word_bits  = FULL_BITS; // R6
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
endmodule // aoc_controller

// *** tb/aoc_link_sva.sv ***
// Checker for the controller-to-device output word link
`timescale 1ns/100ps
module aoc_link_sva
    import aoc_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [15:0] word,
    input wire logic        word_valid,
    input wire logic [4:0]  word_bits
);
    logic seen_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    // Marks that a word went out since reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            seen_r <= 1'b0;
        else if (word_valid)
            seen_r <= 1'b1;
    end
    // Burst head and tail steps
    sequence s_head;
        word_valid && word[13:12] == 2'h0 ##1 word_valid && word[13:12] == 2'h1;
    endsequence
    sequence s_tail;
        word_valid && word[13:12] == 2'h2 ##1 word_valid && word[13:12] == 2'h3;
    endsequence
    ////////////////////////////////////////
    chk_bits_full: assert property (word_valid |-> word_bits == FULL_BITS)
        else $error("word sent short");
    chk_word_steady: assert property (!$stable(word) |-> word_valid)
        else $error("word changed without strobe");
    chk_top_clear: assert property (word_valid |-> !word[15])
        else $error("unused bit set");
    chk_burst_step: assert property (word_valid ##1 word_valid |->
        word[13:12] == $past(word[13:12]) + 2'h1)
        else $error("burst select skipped");
    chk_burst_run: assert property (s_head |=> s_tail)
        else $error("burst cut short");
    chk_burst_end: assert property (word_valid && word[13:12] == 2'h3 |=> !word_valid)
        else $error("word after channel four");
    chk_scan_gap: assert property ($fell(word_valid) |-> !word_valid [*3])
        else $error("words too close");
    chk_first_ch1: assert property (word_valid && !seen_r |-> word[13:12] == 2'h0)
        else $error("first word not channel one");
endmodule // aoc_link_sva

// *** tb/testbench.sv ***
// Testbench for controller and device joined by the word link
`timescale 1ns/100ps
module testbench
    import aoc_pkg::*;
;
    logic             clk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]       avs_address;
    logic [31:0]      avs_writedata, avs_readdata, q;
    logic [3:0][14:0] cur_a, cur_b;
    logic             on_a, on_b, tak_b, drop_b, prev_v, b2b_clr;
    logic [11:0]      dv [4];
    int               error_cnt, n_checks, b2b;
    aoc_if link();
    aoc_if link_b();
    ////////////////////////////////////////
    aoc_controller #(.SCAN_LEN(8)) i_aoc_controller (.clk(clk), .nrst(nrst), .link(link),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    aoc_device i_aoc_device (.clk(clk), .nrst(nrst), .link(link), .ch_current_ua(cur_a),
        .outputs_on(on_a), .word_taken(), .word_dropped());
    aoc_device i_aoc_device_b (.clk(clk), .nrst(nrst), .link(link_b), .ch_current_ua(cur_b),
        .outputs_on(on_b), .word_taken(tak_b), .word_dropped(drop_b));
    aoc_link_sva i_aoc_link_sva (.clk(clk), .nrst(nrst), .word(link.word),
        .word_valid(link.word_valid), .word_bits(link.word_bits));
    ////////////////////////////////////////
    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Counts back-to-back words
    always @(posedge clk) begin
        if (b2b_clr)
            b2b <= 0;
        else if (link.word_valid && prev_v)
            b2b <= b2b + 1;
        prev_v <= link.word_valid;
    end
    ////////////////////////////////////////
    function automatic logic [14:0] cur(input logic [11:0] d);
        return 15'(4000 + (16000 * int'(d)) / 4095);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Avalon transfer, held until waitrequest low
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            final_report();
        end
    endtask
    task automatic data(input logic [11:0] a, b, c, d);
        dv = '{a, b, c, d};
        for (int i = 0; i < 4; i++)
            av(1'b1, OFS_DATA0 + 5'(4 * i), {20'hfffff, dv[i]});
    endtask
    task automatic go(input logic [31:0] ctrl, input logic on);
        av(1'b1, OFS_CTRL, ctrl);
        repeat (16) @(posedge clk);
        b2b_clr <= 1'b1;
        @(posedge clk);
        b2b_clr <= 1'b0;
        repeat (47) @(posedge clk);
        for (int i = 0; i < 4; i++)
            chk($sformatf("current%0d", i), 32'(cur(dv[i])), 32'(cur_a[i]));
        chk("outputs_on", 32'(on), 32'(on_a));
    endtask
    task automatic send_b(input logic [15:0] w, input logic [4:0] bits);
        @(posedge clk);
        link_b.word <= w;
        link_b.word_bits <= bits;
        link_b.word_valid <= 1'b1;
        @(posedge clk);
        link_b.word_valid <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////
    task automatic t_regs;
        chk("current0", 32'h0, 32'(cur_a[0]));
        av(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", 32'(CTRL_RESET), q);
        av(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h0000_0060, q);
        av(1'b1, OFS_DATA0, 32'hffff_f5a5);
        av(1'b0, OFS_DATA0, 32'h0);
        chk("data0", 32'h0000_05a5, q);
        av(1'b1, 5'h18, 32'hffffffff);
        av(1'b0, 5'h18, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask
    task automatic t_modes;
        data(12'h000, 12'hfff, 12'h123, 12'h800);
        go(32'h13, 1'b1);
        data(12'h7ff, 12'h001, 12'hffe, 12'h400);
        go(32'h11, 1'b1);
        data(12'h0aa, 12'h155, 12'h2aa, 12'h355);
        go(32'h15, 1'b1);
        chk("burst_b2b", 32'h1, 32'(b2b > 0));
        data(12'h111, 12'h222, 12'h333, 12'h444);
        go(32'h1d, 1'b1);
        chk("remote_b2b", 32'h0, 32'(b2b));
        go(32'h03, 1'b0);
    endtask
    task automatic t_hold;
        av(1'b1, OFS_CTRL, 32'h0);
        for (int i = 0; i < 4; i++)
            av(1'b1, OFS_DATA0 + 5'(4 * i), 32'h0aa);
        repeat (48) @(posedge clk);
        for (int i = 0; i < 4; i++)
            chk("held", 32'(cur(dv[i])), 32'(cur_a[i]));
    endtask
    task automatic t_partial;
        send_b(16'h5321, FULL_BITS);
        chk("taken", 32'h1, 32'(tak_b));
        chk("ch2", 32'(cur(12'h321)), 32'(cur_b[1]));
        send_b(16'h1555, 5'h0c);
        chk("dropped", 32'h1, 32'(drop_b));
        chk("not_taken", 32'h0, 32'(tak_b));
        chk("ch2_kept", 32'(cur(12'h321)), 32'(cur_b[1]));
        chk("on_kept", 32'h1, 32'(on_b));
        send_b(16'hf0ff, FULL_BITS);
        chk("ch4", 32'(cur(12'h0ff)), 32'(cur_b[3]));
        chk("on_ch4", 32'h1, 32'(on_b));
        chk("ch1_idle", 32'h0, 32'(cur_b[0]));
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {link_b.word, link_b.word_bits, link_b.word_valid} = '0;
        {error_cnt, n_checks, b2b_clr} = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_modes();
        t_hold();
        t_partial();
        final_report();
    end
endmodule // testbench
